// ### design/alu2r_exec.sv
// Purpose: execute unit for the two-register instruction group
// Assumes: one instruction in flight; memory answers data with its ready
// Notes: every instruction spends one accept cycle for the register read
//
// Function
// - add, subtract write back; flag kept
// - add with carry; carry out to flag
// - subtract with borrow; borrow to flag
// - checked add/subtract; overflow to flag
// - negate; negate with borrow sets flag
// - and, or, xor, not; flag kept
// - equal and unsigned compares set flag
// - signed compares set flag
// - any equal byte sets flag
// - and test, flag when zero
// - divide setup loads q, m, flag
// - one non-restoring divide step
// - double multiply into both halves
// - long and half multiply latencies
// - byte/word sign or zero extend
// - arithmetic shift, sign fill right
// - logical shift, zero fill right
// - byte swap and word swap
// - extract middle of src:dest
// - indirect stores; sign-extending loads
// - multiply accumulate, pointers advance
// - long multiply takes two to five cycles, half multiply one to three
module alu2r_exec (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic instr_valid_i,
  input wire alu2r_pkg::instr_t instr_i,
  input wire logic contend_i,
  output logic instr_ready_o,
  output logic done_o,
  output logic illegal_o,
  output logic mem_valid_o,
  output alu2r_pkg::mem_req_t mem_req_o,
  input wire logic mem_ready_i,
  input wire logic [31:0] mem_rdata_i,
  output alu2r_pkg::flags_t flags_o,
  output logic [31:0] mac_high_o,
  output logic [31:0] mac_low_o
);

  typedef enum logic [2:0] {S_IDLE, S_EXEC, S_MUL, S_MEM, S_MACN, S_MACM, S_WBN,
                            S_WBM} state_t;

  // ==========================================================
  // shared arithmetic
  function automatic logic [32:0] addsub(input logic [31:0] x, input logic [31:0] y,
                                         input logic ci, input logic sub);
    addsub = sub ? ({1'b0, x} - {1'b0, y} - {32'h0, ci})
                 : ({1'b0, x} + {1'b0, y} + {32'h0, ci});
  endfunction : addsub

  function automatic logic [31:0] sext8(input logic [7:0] x);
    sext8 = {{24{x[7]}}, x};
  endfunction : sext8

  function automatic logic [31:0] sext16(input logic [15:0] x);
    sext16 = {{16{x[15]}}, x};
  endfunction : sext16

  function automatic logic [63:0] mul64(input logic [31:0] x, input logic [31:0] y,
                                        input logic sgn);
    mul64 = {{32{x[31] & sgn}}, x} * {{32{y[31] & sgn}}, y};
  endfunction : mul64

  // ==========================================================
  // state and operands
  state_t st_q;
  alu2r_pkg::instr_t ir_q;
  alu2r_pkg::flags_t flags_q;
  alu2r_pkg::mem_req_t mreq_q;
  logic [7:0] key;
  logic [7:0] in_key;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] pn_q;
  logic [31:0] pm_q;
  logic [31:0] mn_q;
  logic [31:0] inc;
  logic [2:0] cnt_q;
  logic [63:0] prod_q;
  logic [63:0] pv;
  logic hi_q;
  logic acc_q;
  logic [31:0] mac_high_q;
  logic [31:0] mac_low_q;
  logic accept;
  logic fire;
  logic mul_commit;
  logic mem_ack;
  logic [3:0] ra;
  logic [3:0] rb;
  logic rf_we;
  logic [3:0] rf_wa;
  logic [31:0] rf_wd;

  assign key = {ir_q.grp, ir_q.fn};
  assign in_key = {instr_i.grp, instr_i.fn};
  assign accept = ce_i && st_q == S_IDLE && instr_valid_i;
  assign fire = ce_i && st_q == S_EXEC;
  assign mem_ack = ce_i && mem_valid_o && mem_ready_i;
  assign inc = (key == alu2r_pkg::OP_MAC_LOW) ? alu2r_pkg::PTR_INC_L : alu2r_pkg::PTR_INC_W;

  // read addresses follow the incoming word while idle
  assign ra = (st_q == S_IDLE) ? instr_i.dst : ir_q.dst;
  assign rb = (st_q == S_IDLE) ? instr_i.src : ir_q.src;

  alu2r_regfile u_rf (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .ra_i(ra),
    .rb_i(rb),
    .we_i(rf_we),
    .wa_i(rf_wa),
    .wd_i(rf_wd),
    .qa_o(a),
    .qb_o(b)
  );

  // ==========================================================
  // execute-cycle decode
  logic d_wen;
  logic [31:0] d_wd;
  logic d_twe;
  logic d_tn;
  logic d_qwe;
  logic d_qn;
  logic d_mul;
  logic d_hi;
  logic [63:0] d_prod;
  logic d_bad;
  state_t d_nxt;
  logic [32:0] r33;
  logic [5:0] nsh;

  always_comb begin
    d_wen = 1'b1;
    d_wd = alu2r_pkg::WORD_RST;
    d_twe = 1'b0;
    d_tn = flags_q.t;
    d_qwe = 1'b0;
    d_qn = flags_q.q;
    d_mul = 1'b0;
    d_hi = 1'b0;
    d_prod = alu2r_pkg::MAC_RST;
    d_bad = 1'b0;
    d_nxt = S_IDLE;
    r33 = 33'h0;
    nsh = 6'h20 - {1'b0, b[4:0]};
    unique case (key)
      alu2r_pkg::OP_ADD: d_wd = a + b;
      alu2r_pkg::OP_SUB: d_wd = a - b;
      alu2r_pkg::OP_ADD_WITH_CARRY: begin
        r33 = addsub(a, b, flags_q.t, 1'b0);
        d_wd = r33[31:0];
        d_twe = 1'b1;
        d_tn = r33[32];
      end
      alu2r_pkg::OP_SUBTRACT_WITH_BORROW: begin
        r33 = addsub(a, b, flags_q.t, 1'b1);
        d_wd = r33[31:0];
        d_twe = 1'b1;
        d_tn = r33[32];
      end
      alu2r_pkg::OP_ADD_OVERFLOW_CHECK: begin
        d_wd = a + b;
        d_twe = 1'b1;
        d_tn = (a[31] == b[31]) && (d_wd[31] != a[31]);
      end
      alu2r_pkg::OP_SUBTRACT_UNDERFLOW_CHECK: begin
        d_wd = a - b;
        d_twe = 1'b1;
        d_tn = (a[31] != b[31]) && (d_wd[31] != a[31]);
      end
      alu2r_pkg::OP_NEG: d_wd = 32'h0 - b;
      alu2r_pkg::OP_NEGATE_WITH_BORROW: begin
        r33 = addsub(32'h0, b, flags_q.t, 1'b1);
        d_wd = r33[31:0];
        d_twe = 1'b1;
        d_tn = r33[32];
      end
      alu2r_pkg::OP_AND: d_wd = a & b;
      alu2r_pkg::OP_OR: d_wd = a | b;
      alu2r_pkg::OP_XOR: d_wd = a ^ b;
      alu2r_pkg::OP_NOT: d_wd = ~b;
      alu2r_pkg::OP_CMPEQ, alu2r_pkg::OP_CMPHS, alu2r_pkg::OP_CMPHI,
      alu2r_pkg::OP_CMPGE, alu2r_pkg::OP_CMPGT, alu2r_pkg::OP_CMPSTR,
      alu2r_pkg::OP_TST: begin
        d_wen = 1'b0;
        d_twe = 1'b1;
        if (key == alu2r_pkg::OP_CMPEQ) d_tn = a == b;
        else if (key == alu2r_pkg::OP_CMPHS) d_tn = a >= b;
        else if (key == alu2r_pkg::OP_CMPHI) d_tn = a > b;
        else if (key == alu2r_pkg::OP_CMPGE) d_tn = $signed(a) >= $signed(b);
        else if (key == alu2r_pkg::OP_CMPGT) d_tn = $signed(a) > $signed(b);
        else if (key == alu2r_pkg::OP_TST) d_tn = (a & b) == 32'h0;
        else d_tn = (a[31:24] == b[31:24]) || (a[23:16] == b[23:16]) ||
                    (a[15:8] == b[15:8]) || (a[7:0] == b[7:0]);
      end
      alu2r_pkg::OP_SIGNED_DIVIDE_SETUP: begin
        d_wen = 1'b0;
        d_twe = 1'b1;
        d_qwe = 1'b1;
        d_qn = a[31];
        d_tn = a[31] ^ b[31];
      end
      alu2r_pkg::OP_DIVIDE_STEP: begin
        r33 = addsub({a[30:0], flags_q.t}, b, 1'b0, flags_q.q == flags_q.m);
        d_wd = r33[31:0];
        d_qwe = 1'b1;
        d_qn = a[31] ^ flags_q.m ^ r33[32];
        d_twe = 1'b1;
        d_tn = d_qn == flags_q.m;
      end
      alu2r_pkg::OP_DMULS, alu2r_pkg::OP_DMULU: begin
        d_wen = 1'b0;
        d_mul = 1'b1;
        d_hi = 1'b1;
        d_prod = mul64(a, b, key == alu2r_pkg::OP_DMULS);
      end
      alu2r_pkg::OP_MULL: begin
        d_wen = 1'b0;
        d_mul = 1'b1;
        d_prod = mul64(a, b, 1'b0);
      end
      alu2r_pkg::OP_SIGNED_HALF_MULTIPLY: begin
        d_wen = 1'b0;
        d_mul = 1'b1;
        d_prod = mul64(sext16(a[15:0]), sext16(b[15:0]), 1'b1);
      end
      alu2r_pkg::OP_UNSIGNED_HALF_MULTIPLY: begin
        d_wen = 1'b0;
        d_mul = 1'b1;
        d_prod = mul64({16'h0, a[15:0]}, {16'h0, b[15:0]}, 1'b0);
      end
      alu2r_pkg::OP_EXTSB: d_wd = sext8(b[7:0]);
      alu2r_pkg::OP_EXTSW: d_wd = sext16(b[15:0]);
      alu2r_pkg::OP_EXTUB: d_wd = {24'h0, b[7:0]};
      alu2r_pkg::OP_EXTUW: d_wd = {16'h0, b[15:0]};
      alu2r_pkg::OP_SWAPB: d_wd = {b[31:16], b[7:0], b[15:8]};
      alu2r_pkg::OP_SWAPW: d_wd = {b[15:0], b[31:16]};
      alu2r_pkg::OP_MIDDLE_EXTRACT: d_wd = {b[15:0], a[31:16]};
      alu2r_pkg::OP_ARITH_DYNAMIC_SHIFT, alu2r_pkg::OP_LOGICAL_DYNAMIC_SHIFT: begin
        // sign of the amount picks the direction
        if (!b[31]) d_wd = a << b[4:0];
        else if (key == alu2r_pkg::OP_ARITH_DYNAMIC_SHIFT) d_wd = $signed(a) >>> nsh;
        else d_wd = a >> nsh;
      end
      alu2r_pkg::OP_STB, alu2r_pkg::OP_STW, alu2r_pkg::OP_STL, alu2r_pkg::OP_LDB,
      alu2r_pkg::OP_LDW, alu2r_pkg::OP_LDL: begin
        d_wen = 1'b0;
        d_nxt = S_MEM;
      end
      alu2r_pkg::OP_MAC_LOW, alu2r_pkg::OP_MACW: begin
        d_wen = 1'b0;
        d_nxt = S_MACN;
      end
      default: begin
        d_wen = 1'b0;
        d_bad = 1'b1;
      end
    endcase
    if (d_mul && cnt_q != 3'h1) d_nxt = S_MUL;
  end

  // ==========================================================
  // register write port
  always_comb begin
    rf_we = 1'b0;
    rf_wa = ir_q.dst;
    rf_wd = d_wd;
    if (st_q == S_EXEC) begin
      rf_we = d_wen;
    end else if (st_q == S_MEM && mem_ready_i && !mreq_q.we) begin
      rf_we = 1'b1;
      unique case (mreq_q.size)
        alu2r_pkg::SZ_BYTE: rf_wd = sext8(mem_rdata_i[7:0]);
        alu2r_pkg::SZ_WORD: rf_wd = sext16(mem_rdata_i[15:0]);
        default: rf_wd = mem_rdata_i;
      endcase
    end else if (st_q == S_WBN) begin
      rf_we = 1'b1;
      rf_wd = pn_q + inc;
    end else if (st_q == S_WBM) begin
      rf_we = 1'b1;
      rf_wa = ir_q.src;
      rf_wd = (ir_q.src == ir_q.dst) ? pn_q + {inc[30:0], 1'b0} : pm_q + inc;
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= S_IDLE;
    end else if (ce_i) begin
      unique case (st_q)
        S_IDLE: if (instr_valid_i) st_q <= S_EXEC;
        S_EXEC: st_q <= d_nxt;
        S_MUL: if (cnt_q == 3'h1) st_q <= acc_q ? S_WBN : S_IDLE;
        S_MEM: if (mem_ready_i) st_q <= S_IDLE;
        S_MACN: if (mem_ready_i) st_q <= S_MACM;
        S_MACM: if (mem_ready_i) st_q <= S_MUL;
        S_WBN: st_q <= S_WBM;
        S_WBM: st_q <= S_IDLE;
      endcase
    end
  end

  // instruction latch and latency count
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ir_q <= 16'h0;
      cnt_q <= alu2r_pkg::HMUL_LAT;
    end else if (accept) begin
      ir_q <= instr_i;
      if (in_key == alu2r_pkg::OP_SIGNED_HALF_MULTIPLY || in_key == alu2r_pkg::OP_UNSIGNED_HALF_MULTIPLY) begin
        cnt_q <= contend_i ? alu2r_pkg::HMUL_LAT_MAX : alu2r_pkg::HMUL_LAT;
      end else begin
        cnt_q <= contend_i ? alu2r_pkg::MUL_LAT_MAX : alu2r_pkg::MUL_LAT;
      end
    end else if ((fire && d_mul) || (ce_i && st_q == S_MUL) ||
                 (mem_ack && st_q == S_MACM)) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end

  // condition, quotient and divisor bits
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_q <= alu2r_pkg::FLAGS_RST;
    end else if (fire) begin
      if (d_twe) flags_q.t <= d_tn;
      if (d_qwe) flags_q.q <= d_qn;
      if (key == alu2r_pkg::OP_SIGNED_DIVIDE_SETUP) flags_q.m <= b[31];
    end
  end

  // ==========================================================
  // memory requests and pointer capture
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mreq_q <= '0;
      pn_q <= alu2r_pkg::WORD_RST;
      pm_q <= alu2r_pkg::WORD_RST;
      mn_q <= alu2r_pkg::WORD_RST;
    end else if (fire) begin
      pn_q <= a;
      pm_q <= b;
      mreq_q.wdata <= b;
      mreq_q.we <= ir_q.grp == 4'h2;
      mreq_q.addr <= (ir_q.grp == 4'h6) ? b : a;
      if (d_nxt == S_MACN) begin
        mreq_q.size <= (key == alu2r_pkg::OP_MAC_LOW) ? alu2r_pkg::SZ_LONG
                                                   : alu2r_pkg::SZ_WORD;
      end else begin
        mreq_q.size <= alu2r_pkg::size_t'(ir_q.fn[1:0]);
      end
    end else if (mem_ack && st_q == S_MACN) begin
      mn_q <= mem_rdata_i;
      mreq_q.addr <= pm_q;
    end
  end

  // ==========================================================
  // multiply accumulator
  assign mul_commit = (fire && d_mul && cnt_q == 3'h1) || (ce_i && st_q == S_MUL && cnt_q == 3'h1);
  assign pv = (st_q == S_EXEC) ? d_prod : prod_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prod_q <= alu2r_pkg::MAC_RST;
      hi_q <= 1'b0;
      acc_q <= 1'b0;
    end else if (fire) begin
      prod_q <= d_prod;
      hi_q <= d_hi;
      acc_q <= d_nxt == S_MACN;
    end else if (mem_ack && st_q == S_MACM) begin
      if (key == alu2r_pkg::OP_MAC_LOW) prod_q <= mul64(mn_q, mem_rdata_i, 1'b1);
      else prod_q <= mul64(sext16(mn_q[15:0]), sext16(mem_rdata_i[15:0]), 1'b1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mac_high_q <= alu2r_pkg::WORD_RST;
      mac_low_q <= alu2r_pkg::WORD_RST;
    end else if (mul_commit) begin
      if (st_q == S_MUL && acc_q) {mac_high_q, mac_low_q} <= {mac_high_q, mac_low_q} + pv;
      else if (st_q == S_MUL ? hi_q : d_hi) {mac_high_q, mac_low_q} <= pv;
      else mac_low_q <= pv[31:0];
    end
  end

  // ==========================================================
  // outputs
  assign instr_ready_o = st_q == S_IDLE;
  assign mem_valid_o = st_q == S_MEM || st_q == S_MACN || st_q == S_MACM;
  assign mem_req_o = mreq_q;
  assign flags_o = flags_q;
  assign mac_high_o = mac_high_q;
  assign mac_low_o = mac_low_q;
  assign illegal_o = fire && d_bad;
  assign done_o = (fire && d_nxt == S_IDLE) || (mul_commit && st_q == S_MUL && !acc_q) ||
                  (mem_ack && st_q == S_MEM) || (ce_i && st_q == S_WBM);

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  add_keeps_flag_a: assert property (fire && key == alu2r_pkg::OP_ADD |->
    rf_we && rf_wd == a + b ##1 flags_q.t == $past(flags_q.t))
    else $error("add result or flag wrong");

  add_with_carry_carry_a: assert property (fire && key == alu2r_pkg::OP_ADD_WITH_CARRY |=>
    flags_q.t == $past(({1'b0, a} + {1'b0, b} + {32'h0, flags_q.t}) >> 32))
    else $error("add with carry flag wrong");

  subtract_underflow_check_under_a: assert property (fire && key == alu2r_pkg::OP_SUBTRACT_UNDERFLOW_CHECK |=>
    flags_q.t == $past((a[31] != b[31]) && ((a - b) >> 31) != {31'h0, a[31]}))
    else $error("underflow flag wrong");

  compare_equal_flag_a: assert property (fire && key == alu2r_pkg::OP_CMPEQ |->
    !rf_we ##1 flags_q.t == $past(a == b))
    else $error("equal compare wrong");

  compare_signed_gt_flag_a: assert property (fire && key == alu2r_pkg::OP_CMPGT |=>
    flags_q.t == ($signed($past(a)) > $signed($past(b))))
    else $error("signed compare wrong");

  any_byte_a: assert property (fire && key == alu2r_pkg::OP_CMPSTR |=>
    flags_q.t == $past((a[31:24] == b[31:24]) || (a[23:16] == b[23:16]) ||
    (a[15:8] == b[15:8]) || (a[7:0] == b[7:0])))
    else $error("byte compare result wrong");

  test_zero_a: assert property (fire && key == alu2r_pkg::OP_TST |=>
    flags_q.t == ($past(a & b) == 32'h0))
    else $error("bit test flag wrong");

  div_setup_a: assert property (fire && key == alu2r_pkg::OP_SIGNED_DIVIDE_SETUP |=>
    flags_q.q == $past(a[31]) && flags_q.m == $past(b[31]) &&
    flags_q.t == (flags_q.q ^ flags_q.m))
    else $error("divide setup wrong");

  extract_mid_a: assert property (fire && key == alu2r_pkg::OP_MIDDLE_EXTRACT |->
    rf_wd == {b[15:0], a[31:16]} && rf_wa == ir_q.dst)
    else $error("extract wrong");

  shift_left_a: assert property (fire && key == alu2r_pkg::OP_ARITH_DYNAMIC_SHIFT && !b[31] |->
    rf_wd == a << b[4:0])
    else $error("left shift wrong");

  mul_fast_a: assert property (accept && in_key == alu2r_pkg::OP_DMULU && !contend_i
    ##1 ce_i ##1 ce_i |-> done_o ##1 mac_low_o == $past(prod_q[31:0]))
    else $error("multiply not done after two cycles");

  mul_slow_a: assert property (accept && in_key == alu2r_pkg::OP_MULL && contend_i
    ##1 ce_i[*4] ##1 ce_i |-> done_o)
    else $error("contended multiply not done after five cycles");

  store_addr_a: assert property (fire && key == alu2r_pkg::OP_STL |=>
    mem_valid_o && mem_req_o.we && mem_req_o.addr == $past(a) && mem_req_o.wdata == $past(b))
    else $error("store request wrong");

endmodule : alu2r_exec

// ### design/alu2r_pkg.sv
// Purpose: shared types and constants of the two-register execute unit
// Assumes: opcode key is {group nibble, function nibble} of the instruction
// Notes: latencies are in core clock cycles
package alu2r_pkg;

  // ==========================================================
  // carriers
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_t;
  typedef struct packed {
    logic [3:0] grp;
    logic [3:0] dst;
    logic [3:0] src;
    logic [3:0] fn;
  } instr_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic we;
    size_t size;
  } mem_req_t;
  typedef struct packed {
    logic t;
    logic q;
    logic m;
  } flags_t;

  // ==========================================================
  // reset values
  localparam flags_t FLAGS_RST = 3'h0;
  localparam logic [31:0] WORD_RST = 32'h0;
  localparam logic [63:0] MAC_RST = 64'h0;

  // ==========================================================
  // opcode keys {grp, fn}
  localparam logic [7:0] OP_ADD = 8'h3C;
  localparam logic [7:0] OP_ADD_WITH_CARRY = 8'h3E;
  localparam logic [7:0] OP_ADD_OVERFLOW_CHECK = 8'h3F;
  localparam logic [7:0] OP_SUB = 8'h38;
  localparam logic [7:0] OP_SUBTRACT_WITH_BORROW = 8'h3A;
  localparam logic [7:0] OP_SUBTRACT_UNDERFLOW_CHECK = 8'h3B;
  localparam logic [7:0] OP_CMPEQ = 8'h30;
  localparam logic [7:0] OP_CMPHS = 8'h32;
  localparam logic [7:0] OP_CMPGE = 8'h33;
  localparam logic [7:0] OP_CMPHI = 8'h36;
  localparam logic [7:0] OP_CMPGT = 8'h37;
  localparam logic [7:0] OP_DIVIDE_STEP = 8'h34;
  localparam logic [7:0] OP_DMULS = 8'h3D;
  localparam logic [7:0] OP_DMULU = 8'h35;
  localparam logic [7:0] OP_AND = 8'h29;
  localparam logic [7:0] OP_OR = 8'h2B;
  localparam logic [7:0] OP_XOR = 8'h2A;
  localparam logic [7:0] OP_CMPSTR = 8'h2C;
  localparam logic [7:0] OP_TST = 8'h28;
  localparam logic [7:0] OP_SIGNED_DIVIDE_SETUP = 8'h27;
  localparam logic [7:0] OP_MIDDLE_EXTRACT = 8'h2D;
  localparam logic [7:0] OP_SIGNED_HALF_MULTIPLY = 8'h2F;
  localparam logic [7:0] OP_UNSIGNED_HALF_MULTIPLY = 8'h2E;
  localparam logic [7:0] OP_STB = 8'h20;
  localparam logic [7:0] OP_STW = 8'h21;
  localparam logic [7:0] OP_STL = 8'h22;
  localparam logic [7:0] OP_NEG = 8'h6B;
  localparam logic [7:0] OP_NEGATE_WITH_BORROW = 8'h6A;
  localparam logic [7:0] OP_NOT = 8'h67;
  localparam logic [7:0] OP_EXTSB = 8'h6E;
  localparam logic [7:0] OP_EXTSW = 8'h6F;
  localparam logic [7:0] OP_EXTUB = 8'h6C;
  localparam logic [7:0] OP_EXTUW = 8'h6D;
  localparam logic [7:0] OP_SWAPB = 8'h68;
  localparam logic [7:0] OP_SWAPW = 8'h69;
  localparam logic [7:0] OP_LDB = 8'h60;
  localparam logic [7:0] OP_LDW = 8'h61;
  localparam logic [7:0] OP_LDL = 8'h62;
  localparam logic [7:0] OP_MULL = 8'h07;
  localparam logic [7:0] OP_MAC_LOW = 8'h0F;
  localparam logic [7:0] OP_MACW = 8'h4F;
  localparam logic [7:0] OP_ARITH_DYNAMIC_SHIFT = 8'h4C;
  localparam logic [7:0] OP_LOGICAL_DYNAMIC_SHIFT = 8'h4D;

  // ==========================================================
  // timing and pointer steps
  localparam logic [2:0] MUL_LAT = 3'h2;
  localparam logic [2:0] MUL_LAT_MAX = 3'h5;
  localparam logic [2:0] HMUL_LAT = 3'h1;
  localparam logic [2:0] HMUL_LAT_MAX = 3'h3;
  localparam logic [31:0] PTR_INC_L = 32'h4;
  localparam logic [31:0] PTR_INC_W = 32'h2;

endpackage : alu2r_pkg

// ### design/alu2r_regfile.sv
// Purpose: sixteen general registers, two registered reads, one write
// Assumes: read addresses are presented one cycle before the data is used
// Notes: a write and a read of the same entry on one edge return the old value
module alu2r_regfile (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [3:0] ra_i,
  input wire logic [3:0] rb_i,
  input wire logic we_i,
  input wire logic [3:0] wa_i,
  input wire logic [31:0] wd_i,
  output logic [31:0] qa_o,
  output logic [31:0] qb_o
);

  logic [31:0] mem_q [16];

  // ==========================================================
  // write port
  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem_q[wa_i] <= wd_i;
    end
  end

  // registered read ports
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      qa_o <= alu2r_pkg::WORD_RST;
      qb_o <= alu2r_pkg::WORD_RST;
    end else if (ce_i) begin
      qa_o <= mem_q[ra_i];
      qb_o <= mem_q[rb_i];
    end
  end

endmodule : alu2r_regfile

// ### verification/alu2r_mem_model.sv
// Purpose: data memory partner of the execute unit
// Assumes: ready after delay_i waiting cycles; boot_i returns boot data
// Notes: non-ready read data is the inverse of the read data of the last non-waiting cycle
module alu2r_mem_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic mem_valid_i,
  input wire alu2r_pkg::mem_req_t mem_req_i,
  input wire logic [2:0] delay_i,
  input wire logic boot_i,
  input wire logic [31:0] boot_data_i,
  output logic mem_ready_o,
  output logic [31:0] mem_rdata_o
);
  logic [31:0] mem [16];
  logic [31:0] last_q;
  logic [2:0] cnt_q;
  alu2r_pkg::mem_req_t last_wr;
  // ==========================================================
  // wait counter and answer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 3'h0;
      last_q <= 32'h0;
    end else if (mem_valid_i && !mem_ready_o) begin
      cnt_q <= cnt_q + 3'h1;
    end else begin
      cnt_q <= 3'h0;
      last_q <= mem_rdata_o;
    end
  end
  assign mem_ready_o = mem_valid_i && (cnt_q >= delay_i);
  assign mem_rdata_o = !mem_ready_o ? ~last_q : boot_i ? boot_data_i : mem[mem_req_i.addr[5:2]];
  // store capture
  always @(posedge clk_i) begin
    if (mem_ready_o && mem_req_i.we) begin
      mem[mem_req_i.addr[5:2]] <= mem_req_i.wdata;
      last_wr <= mem_req_i;
    end
  end
endmodule : alu2r_mem_model

// ### verification/two_register_alu_datapath_tb.sv
// Purpose: self-checking bench of the two-register execute unit
// Assumes: registers are seeded by loads of boot data
// Notes: results are read back through long stores
module two_register_alu_datapath_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_b_i, valid, contend, ready, done, ill, mvalid, mready, boot, ce;
  alu2r_pkg::instr_t instr;
  alu2r_pkg::mem_req_t mreq;
  alu2r_pkg::flags_t flags;
  logic [31:0] rdata, mac_hi, mac_lo, boot_data;
  logic [2:0] delay;
  int n_errors, n_tests, lat;
  logic saw_ill;
  alu2r_exec dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .instr_valid_i(valid),
    .instr_i(instr), .contend_i(contend), .instr_ready_o(ready), .done_o(done),
    .illegal_o(ill), .mem_valid_o(mvalid), .mem_req_o(mreq), .mem_ready_i(mready),
    .mem_rdata_i(rdata), .flags_o(flags), .mac_high_o(mac_hi), .mac_low_o(mac_lo));
  alu2r_mem_model mm (.clk_i(clk_i), .rst_b_i(rst_b_i), .mem_valid_i(mvalid),
    .mem_req_i(mreq), .delay_i(delay), .boot_i(boot), .boot_data_i(boot_data),
    .mem_ready_o(mready), .mem_rdata_o(rdata));
  // ==========================================================
  // tasks
  task automatic final_report();
    $display("errors %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // offer one instruction, wait for its done pulse
  task automatic exec(input logic [15:0] op, input logic con);
    @(negedge clk_i);
    instr = op;
    contend = con;
    valid = 1'h1;
    @(negedge clk_i);
    valid = 1'h0;
    lat = 1;
    while (done !== 1'h1 && lat < 20) begin
      @(negedge clk_i);
      lat++;
    end
    saw_ill = ill;
    if (lat >= 20) begin
      n_errors++;
      final_report();
    end
    // let the committing edge pass before results are read
    @(negedge clk_i);
  endtask : exec
  task automatic ld(input logic [3:0] r, input logic [31:0] v);
    boot_data = v;
    boot = 1'h1;
    exec({4'h6, r, r, 4'h2}, 1'h0);
    boot = 1'h0;
  endtask : ld
  task automatic st_chk(input logic [3:0] r, input logic [31:0] v);
    exec({4'h2, 4'hF, r, 4'h2}, 1'h0);
    check(mm.last_wr.wdata, v);
  endtask : st_chk
  // seed operands and flag, run op dest r1 src r2, check flag and result
  task automatic run(input logic [7:0] k, input logic [31:0] a, input logic [31:0] b,
                     input logic t, input logic [31:0] r, input logic tx);
    ld(4'h1, a);
    ld(4'h2, b);
    exec({4'h3, 4'h3, 4'h3, t ? 4'h0 : 4'h6}, 1'h0);
    exec({k[7:4], 4'h1, 4'h2, k[3:0]}, 1'h0);
    check(32'(flags.t), 32'(tx));
    st_chk(4'h1, r);
  endtask : run
  // ==========================================================
  // clock and sequence
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    rst_b_i = 1'h0;
    ce = 1'h1;
    valid = 1'h0;
    instr = 16'h0;
    contend = 1'h0;
    boot = 1'h0;
    boot_data = 32'h0;
    delay = 3'h0;
    n_errors = 0;
    n_tests = 0;
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'h1;
    check({29'h0, flags}, 32'h0);
    ld(4'hF, 32'h40);
    ld(4'h3, 32'h0);
    check(32'(lat), 32'h2);
    run(8'h3C, 32'h7FFFFFFF, 32'h1, 1'h1, 32'h80000000, 1'h1);
    run(8'h3E, 32'hFFFFFFFF, 32'h0, 1'h1, 32'h0, 1'h1);
    run(8'h3A, 32'h5, 32'h5, 1'h1, 32'hFFFFFFFF, 1'h1);
    run(8'h3F, 32'h7FFFFFFF, 32'h1, 1'h0, 32'h80000000, 1'h1);
    run(8'h3F, 32'h1, 32'h1, 1'h1, 32'h2, 1'h0);
    run(8'h3B, 32'h80000000, 32'h1, 1'h0, 32'h7FFFFFFF, 1'h1);
    run(8'h6A, 32'h0, 32'h0, 1'h1, 32'hFFFFFFFF, 1'h1);
    run(8'h29, 32'hF0F0, 32'hFF00, 1'h1, 32'hF000, 1'h1);
    run(8'h67, 32'h0, 32'hFFFF, 1'h0, 32'hFFFF0000, 1'h0);
    run(8'h32, 32'h1, 32'hFFFFFFFF, 1'h1, 32'h1, 1'h0);
    run(8'h33, 32'hFFFFFFFF, 32'h1, 1'h1, 32'hFFFFFFFF, 1'h0);
    run(8'h37, 32'h1, 32'hFFFFFFFF, 1'h0, 32'h1, 1'h1);
    run(8'h2C, 32'h12345678, 32'hAB34CDEF, 1'h0, 32'h12345678, 1'h1);
    run(8'h28, 32'hF0, 32'hF, 1'h0, 32'hF0, 1'h1);
    run(8'h6E, 32'h0, 32'h80, 1'h1, 32'hFFFFFF80, 1'h1);
    run(8'h68, 32'h0, 32'hAABB1234, 1'h0, 32'hAABB3412, 1'h0);
    run(8'h2D, 32'h11112222, 32'h33334444, 1'h0, 32'h44441111, 1'h0);
    run(8'h4C, 32'h80000000, 32'hFFFFFFFC, 1'h1, 32'hF8000000, 1'h1);
    run(8'h4D, 32'h80000000, 32'hFFFFFFFC, 1'h0, 32'h08000000, 1'h0);
    run(8'h27, 32'h80000000, 32'h0, 1'h0, 32'h80000000, 1'h1);
    check({29'h0, flags}, 32'h6);
    run(8'h34, 32'h1, 32'h1, 1'h1, 32'h4, 1'h1);
    check({29'h0, flags}, 32'h4);
    run(8'h35, 32'hFFFFFFFF, 32'h2, 1'h1, 32'hFFFFFFFF, 1'h1);
    check(mac_hi, 32'h1);
    exec(16'h312D, 1'h1);
    check(32'(lat), 32'h5);
    check(mac_hi, 32'hFFFFFFFF);
    exec(16'h212F, 1'h0);
    check(32'(lat), 32'h1);
    check(mac_lo, 32'hFFFFFFFE);
    exec(16'h212E, 1'h1);
    check(32'(lat), 32'h3);
    check(mac_lo, 32'h0001FFFE);
    exec(16'h0127, 1'h0);
    check(32'(lat), 32'h2);
    exec(16'h0127, 1'h1);
    check(32'(lat), 32'h5);
    check(mac_lo, 32'hFFFFFFFE);
    // one frozen cycle stretches the long multiply by one
    fork
      exec(16'h0127, 1'h0);
      begin
        repeat (2) @(negedge clk_i);
        ce = 1'h0;
        @(negedge clk_i);
        ce = 1'h1;
      end
    join
    check(32'(lat), 32'h3);
    ld(4'h4, 32'h10);
    ld(4'h5, 32'h20);
    mm.mem[4] = 32'h3;
    mm.mem[8] = 32'hFFFFFFFE;
    exec(16'h045F, 1'h0);
    check(mac_lo, 32'hFFFFFFF8);
    st_chk(4'h4, 32'h14);
    st_chk(4'h5, 32'h24);
    delay = 3'h3;
    exec(16'h2F20, 1'h0);
    check(32'(lat), 32'h5);
    check({30'h0, mm.last_wr.size}, 32'(alu2r_pkg::SZ_BYTE));
    delay = 3'h0;
    boot_data = 32'h12345680;
    boot = 1'h1;
    exec(16'h6110, 1'h0);
    boot = 1'h0;
    st_chk(4'h1, 32'hFFFFFF80);
    exec(16'h6123, 1'h0);
    check(32'(saw_ill), 32'h1);
    final_report();
  end
endmodule : two_register_alu_datapath_tb
